/* core/dtp_defines.vh */
// constants for the dual counter/timer with capture and ping-pong
`ifndef DTP_DEFINES_VH
`define DTP_DEFINES_VH
// register offsets within the expanded bank
`define DTP_OFF_SHORT_CTRL   4'h0
`define DTP_OFF_SHARED_CTRL  4'h1
`define DTP_OFF_LONG_CTRL    4'h2
`define DTP_OFF_SHORT_LOW    4'h4
`define DTP_OFF_SHORT_HIGH   4'h5
`define DTP_OFF_LONG_LOW     4'h6
`define DTP_OFF_LONG_HIGH    4'h7
`define DTP_OFF_LCAP_LOW     4'h8
`define DTP_OFF_LCAP_HIGH    4'h9
`define DTP_OFF_SCAP_LOW     4'hA
`define DTP_OFF_SCAP_HIGH    4'hB
// bank pointer low nibble that selects the timer bank
`define DTP_TIMER_BANK       4'hD
// short and long control register fields
`define DTP_B_RUN            7
`define DTP_B_SINGLE         6
`define DTP_B_TIMEOUT        5
`define DTP_B_PRE_HI         4
`define DTP_B_PRE_LO         3
`define DTP_B_CAP_IE         2
`define DTP_B_TC_IE          1
// shared control register fields
`define DTP_B_DEMOD          6
`define DTP_B_FALL           5
`define DTP_B_RISE           4
`define DTP_B_PP_HI          3
`define DTP_B_PP_LO          2
`define DTP_B_SINIT          1
`define DTP_B_LINIT          0
`define DTP_PP_ON            2'h1
// reset, wrap and reload values
`define DTP_CTRL_RST         8'h00
`define DTP_HOLD_RST         8'h00
`define DTP_CAP_RST          8'h00
`define DTP_LONG_WRAP        16'hFFFF
`define DTP_SHORT_FULL       8'hFF
`endif

/* core/dtp_timer.v */
// dual down counter/timer with capture, demodulation and ping-pong
`timescale 1ns/1ps
`include "dtp_defines.vh"

module dtp_timer (
  // clock and reset
  input  wire       clock,
  input  wire       arst_n,
  // register file port
  input  wire [7:0] bank_pointer,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_hit,
  // pulse input and waveform outputs
  input  wire       signal_in,
  output reg        short_wave_out,
  output reg        long_wave_out,
  // interrupt requests to the controller
  output reg        short_timer_request,
  output reg        long_timer_request
);

  reg  [7:0]  short_ctrl_q;
  reg  [7:0]  shared_ctrl_q;
  reg  [7:0]  long_ctrl_q;
  reg  [7:0]  short_low_hold_q;
  reg  [7:0]  short_high_hold_q;
  reg  [7:0]  long_low_hold_q;
  reg  [7:0]  long_high_hold_q;
  reg  [15:0] long_capture_q;
  reg  [7:0]  short_capture_low_q;
  reg  [7:0]  short_capture_high_q;
  reg  [7:0]  short_cnt_q;
  reg  [15:0] long_cnt_q;
  reg  [2:0]  div_q;
  reg         sig_q;
  reg         short_run_prev_q;
  reg         long_run_prev_q;
  reg         arm_q;

  // bank decode: only the low sixteen addresses with bank D
  wire sel = (bank_pointer[3:0] == `DTP_TIMER_BANK) &&
             (reg_addr[7:4] == 4'h0);
  wire [3:0] off = reg_addr[3:0];
  wire wr_short  = reg_wr && sel && (off == `DTP_OFF_SHORT_CTRL);
  wire wr_shared = reg_wr && sel && (off == `DTP_OFF_SHARED_CTRL);
  wire wr_long   = reg_wr && sel && (off == `DTP_OFF_LONG_CTRL);

  // mode decode
  wire demod   = shared_ctrl_q[`DTP_B_DEMOD];
  wire pp_mode = !demod &&
    (shared_ctrl_q[`DTP_B_PP_HI:`DTP_B_PP_LO] == `DTP_PP_ON);
  wire s_run   = short_ctrl_q[`DTP_B_RUN];
  wire l_run   = long_ctrl_q[`DTP_B_RUN];
  wire s_start = s_run && !short_run_prev_q;
  wire l_start = l_run && !long_run_prev_q;

  // prescaler tick for the short counter
  wire [1:0] pre = short_ctrl_q[`DTP_B_PRE_HI:`DTP_B_PRE_LO];
  reg  [2:0] pre_mask;
  always @* begin
    case (pre)
      2'h0:    pre_mask = 3'h0;   // system clock
      2'h1:    pre_mask = 3'h1;   // half
      2'h2:    pre_mask = 3'h3;   // quarter
      default: pre_mask = 3'h7;   // eighth
    endcase
  end
  wire s_tick = ((div_q & pre_mask) == pre_mask);

  // input edges
  wire rise     = signal_in && !sig_q;
  wire fall     = !signal_in && sig_q;
  wire any_edge = rise || fall;
  wire sel_edge = (rise && shared_ctrl_q[`DTP_B_RISE]) ||
                  (fall && shared_ctrl_q[`DTP_B_FALL]);

  // short counter events
  wire s_tc      = s_run && !s_start && s_tick && (short_cnt_q == 8'h01);
  wire s_cap     = demod && s_run && any_edge;
  // short wave level used to pick the hold register
  wire s_lvl     = (pp_mode && s_start) ? shared_ctrl_q[`DTP_B_SINIT]
                                        : short_wave_out;
  wire [7:0] s_hold    = s_lvl ? short_high_hold_q : short_low_hold_q;
  wire [7:0] s_hold_nx = s_lvl ? short_low_hold_q : short_high_hold_q;

  // long counter events
  wire [15:0] l_hold = {long_high_hold_q, long_low_hold_q};
  wire l_tc_tx   = !demod && l_run && !l_start && (long_cnt_q == 16'h0001);
  wire l_zero    = demod && l_run && (long_cnt_q == 16'h0000);
  wire l_hold_md = long_ctrl_q[`DTP_B_SINGLE];
  wire l_edgecap = demod && l_run && sel_edge && (!l_hold_md || arm_q);
  wire l_tocap   = demod && l_run && l_hold_md && s_tc;
  wire arm_set   = wr_long && reg_wdata[`DTP_B_SINGLE] &&
                   !long_ctrl_q[`DTP_B_SINGLE];

  // sampled input, divider and start detectors
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q            <= 3'h0;
      sig_q            <= 1'b0;
      short_run_prev_q <= 1'b0;
      long_run_prev_q  <= 1'b0;
    end else begin
      div_q            <= div_q + 3'h1;
      sig_q            <= signal_in;
      short_run_prev_q <= s_run;
      long_run_prev_q  <= l_run;
    end
  end

  // hold registers, written by software only
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      short_low_hold_q  <= `DTP_HOLD_RST;
      short_high_hold_q <= `DTP_HOLD_RST;
      long_low_hold_q   <= `DTP_HOLD_RST;
      long_high_hold_q  <= `DTP_HOLD_RST;
    end else if (reg_wr && sel) begin
      if (off == `DTP_OFF_SHORT_LOW)
        short_low_hold_q <= reg_wdata;
      else if (off == `DTP_OFF_SHORT_HIGH)
        short_high_hold_q <= reg_wdata;
      else if (off == `DTP_OFF_LONG_LOW)
        long_low_hold_q <= reg_wdata;
      else if (off == `DTP_OFF_LONG_HIGH)
        long_high_hold_q <= reg_wdata;
    end
  end

  // control registers: software write, then hardware updates
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      short_ctrl_q  <= `DTP_CTRL_RST;
      shared_ctrl_q <= `DTP_CTRL_RST;
      long_ctrl_q   <= `DTP_CTRL_RST;
    end else begin
      if (wr_short) begin
        short_ctrl_q[7:6] <= reg_wdata[7:6];
        short_ctrl_q[4:0] <= reg_wdata[4:0];
        if (reg_wdata[`DTP_B_TIMEOUT])
          short_ctrl_q[`DTP_B_TIMEOUT] <= 1'b0;
      end
      if (wr_shared)
        shared_ctrl_q <= reg_wdata;
      if (wr_long) begin
        long_ctrl_q[7:6] <= reg_wdata[7:6];
        long_ctrl_q[4:0] <= reg_wdata[4:0];
        if (reg_wdata[`DTP_B_TIMEOUT])
          long_ctrl_q[`DTP_B_TIMEOUT] <= 1'b0;
      end
      // timeout flags: a set beats a clear in the same cycle
      if (s_tc)
        short_ctrl_q[`DTP_B_TIMEOUT] <= 1'b1;
      if (l_tc_tx || l_zero)
        long_ctrl_q[`DTP_B_TIMEOUT] <= 1'b1;
      // single pass stops; ping-pong swaps the run bits
      if (s_tc && !demod && (pp_mode || short_ctrl_q[`DTP_B_SINGLE]))
        short_ctrl_q[`DTP_B_RUN] <= 1'b0;
      if (s_tc && pp_mode)
        long_ctrl_q[`DTP_B_RUN] <= 1'b1;
      if (l_tc_tx && (pp_mode || long_ctrl_q[`DTP_B_SINGLE]))
        long_ctrl_q[`DTP_B_RUN] <= 1'b0;
      if (l_tc_tx && pp_mode)
        short_ctrl_q[`DTP_B_RUN] <= 1'b1;
    end
  end

  // one-shot arm for long mark-time capture
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      arm_q <= 1'b0;
    else if (arm_set)
      arm_q <= 1'b1;
    else if (l_edgecap || !long_ctrl_q[`DTP_B_SINGLE])
      arm_q <= 1'b0;
  end

  // short counter, wave output and captures
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      short_cnt_q          <= 8'h00;
      short_wave_out       <= 1'b0;
      short_capture_low_q  <= `DTP_CAP_RST;
      short_capture_high_q <= `DTP_CAP_RST;
    end else if (demod) begin
      if (s_cap) begin
        // count since last edge, filed by the level just ended
        if (sig_q)
          short_capture_high_q <= `DTP_SHORT_FULL - short_cnt_q;
        else
          short_capture_low_q <= `DTP_SHORT_FULL - short_cnt_q;
        short_cnt_q <= `DTP_SHORT_FULL;
      end else if (s_start || s_tc) begin
        short_cnt_q <= `DTP_SHORT_FULL;
      end else if (s_run && s_tick) begin
        short_cnt_q <= short_cnt_q - 8'h01;
      end
    end else if (s_start) begin
      short_wave_out <= s_lvl;
      short_cnt_q    <= s_hold;
    end else if (s_tc) begin
      short_wave_out <= !short_wave_out;
      short_cnt_q    <= s_hold_nx;
    end else if (s_run && s_tick) begin
      short_cnt_q <= short_cnt_q - 8'h01;
    end
  end

  // long counter, wave output and capture
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      long_cnt_q     <= 16'h0000;
      long_wave_out  <= 1'b0;
      long_capture_q <= {`DTP_CAP_RST, `DTP_CAP_RST};
    end else if (demod) begin
      if (l_start) begin
        long_cnt_q <= l_hold;
      end else if (l_edgecap) begin
        long_capture_q <= long_cnt_q;
        long_cnt_q     <= l_hold;
      end else if (l_run) begin
        if (l_tocap)
          long_capture_q <= long_cnt_q;
        if (l_zero)
          long_cnt_q <= `DTP_LONG_WRAP;
        else
          long_cnt_q <= long_cnt_q - 16'h0001;
      end
    end else if (l_start) begin
      if (pp_mode)
        long_wave_out <= shared_ctrl_q[`DTP_B_LINIT];
      long_cnt_q <= l_hold;
    end else if (l_tc_tx) begin
      long_wave_out <= !long_wave_out;
      long_cnt_q    <= l_hold;
    end else if (l_run) begin
      long_cnt_q <= long_cnt_q - 16'h0001;
    end
  end

  // interrupt request pulses
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      short_timer_request <= 1'b0;
      long_timer_request  <= 1'b0;
    end else begin
      short_timer_request <=
        (s_tc && short_ctrl_q[`DTP_B_TC_IE]) ||
        (s_cap && short_ctrl_q[`DTP_B_CAP_IE]);
      long_timer_request <=
        ((l_tc_tx || l_zero) && long_ctrl_q[`DTP_B_TC_IE]) ||
        ((l_tocap || l_edgecap) &&
         long_ctrl_q[`DTP_B_CAP_IE]);
    end
  end

  // read data mux; captures ignore writes
  reg [7:0] rd_mux;
  always @* begin
    if (off == `DTP_OFF_SHORT_CTRL)
      rd_mux = short_ctrl_q;
    else if (off == `DTP_OFF_SHARED_CTRL)
      rd_mux = shared_ctrl_q;
    else if (off == `DTP_OFF_LONG_CTRL)
      rd_mux = long_ctrl_q;
    else if (off == `DTP_OFF_SHORT_LOW)
      rd_mux = short_low_hold_q;
    else if (off == `DTP_OFF_SHORT_HIGH)
      rd_mux = short_high_hold_q;
    else if (off == `DTP_OFF_LONG_LOW)
      rd_mux = long_low_hold_q;
    else if (off == `DTP_OFF_LONG_HIGH)
      rd_mux = long_high_hold_q;
    else if (off == `DTP_OFF_LCAP_LOW)
      rd_mux = long_capture_q[7:0];
    else if (off == `DTP_OFF_LCAP_HIGH)
      rd_mux = long_capture_q[15:8];
    else if (off == `DTP_OFF_SCAP_LOW)
      rd_mux = short_capture_low_q;
    else if (off == `DTP_OFF_SCAP_HIGH)
      rd_mux = short_capture_high_q;
    else
      rd_mux = 8'h00;
  end

  // registered read answer
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else begin
      reg_hit   <= reg_rd && sel;
      reg_rdata <= (reg_rd && sel) ? rd_mux : 8'h00;
    end
  end

endmodule

/* test/dtp_timer_asserts.sv */
// port checker for the dual timer
`timescale 1ns/1ps
module dtp_timer_asserts (
  // clock and reset
  input wire       clock,
  input wire       arst_n,
  // register port
  input wire [7:0] bank_pointer,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       reg_hit,
  // pins and requests
  input wire       signal_in,
  input wire       short_wave_out,
  input wire       long_wave_out,
  input wire       short_timer_request,
  input wire       long_timer_request
);
  // access falls in the timer bank
  wire sel = bank_pointer[3:0] == 4'hD && reg_addr[7:4] == 4'h0;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_hit: assert property (reg_rd && sel |=> reg_hit)
    else $error("bank read gave no hit");
  a_bank_miss: assert property (reg_rd && !sel |=> !reg_hit)
    else $error("foreign read gave a hit");
  a_miss_zero: assert property (reg_rd && !sel |=> reg_rdata == 8'h00)
    else $error("foreign read gave data");
  a_idle_data: assert property (!reg_rd
    |=> !reg_hit && reg_rdata == 8'h00)
    else $error("read data without a read");
  a_hold_back: assert property (reg_wr && sel && reg_addr == 8'h05 ##1
    !reg_wr ##1 reg_rd && sel && reg_addr == 8'h05
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("hold readback wrong");
  a_short_pulse: assert property (short_timer_request
    |=> !short_timer_request) else $error("short request too long");
  a_long_pulse: assert property (long_timer_request
    |=> !long_timer_request) else $error("long request too long");
  a_reset_quiet: assert property ($rose(arst_n) |-> !(short_wave_out ||
    long_wave_out || short_timer_request || long_timer_request || reg_hit))
    else $error("outputs busy after reset");
endmodule
bind dtp_timer dtp_timer_asserts u_chk (.clock(clock), .arst_n(arst_n),
  .bank_pointer(bank_pointer), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .signal_in(signal_in),
  .short_wave_out(short_wave_out), .long_wave_out(long_wave_out),
  .short_timer_request(short_timer_request),
  .long_timer_request(long_timer_request));

/* test/dtp_pulse_src.sv */
// pulse source feeding the timer's signal input
`timescale 1ns/1ps
module dtp_pulse_src (
  // clock and reset
  input  wire       clock,
  input  wire       arst_n,
  // pulse shape
  input  wire       run,
  input  wire [7:0] high_len,
  input  wire [7:0] low_len,
  // pulse line
  output reg        signal_in
);
  reg [7:0] cnt_q;
  // alternate levels for the set lengths, idle low
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n || !run) begin
      signal_in <= 1'b0;
      cnt_q     <= 8'h00;
    end else if (cnt_q == 8'h00) begin
      signal_in <= !signal_in;
      cnt_q     <= (signal_in ? low_len : high_len) - 8'h01;
    end else begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

/* test/tb_dual_timer_capture_pingpong.sv */
// self-checking bench for the dual timer
`timescale 1ns/1ps
module tb_dual_timer_capture_pingpong;
  reg        clock        = 1'b0;
  reg        arst_n       = 1'b0;
  reg  [7:0] bank_pointer = 8'h0D;
  reg  [7:0] reg_addr     = 8'h00;
  reg        reg_wr       = 1'b0;
  reg        reg_rd       = 1'b0;
  reg  [7:0] reg_wdata    = 8'h00;
  reg        p_run        = 1'b0;
  wire [7:0] reg_rdata;
  wire       reg_hit, signal_in, s_wave, l_wave, s_req, l_req;
  integer    fails        = 0;
  integer    n_checks     = 0;
  integer    cyc          = 0;
  integer    i;
  reg  [7:0] d, h2;
  reg        h;
  dtp_timer dut (.clock(clock), .arst_n(arst_n),
    .bank_pointer(bank_pointer), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .signal_in(signal_in), .short_wave_out(s_wave),
    .long_wave_out(l_wave), .short_timer_request(s_req),
    .long_timer_request(l_req));
  dtp_pulse_src src (.clock(clock), .arst_n(arst_n), .run(p_run),
    .high_len(8'h14), .low_len(8'h1E), .signal_in(signal_in));
  // clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      if (fails == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [8:0] seen, input [8:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
      h = reg_hit;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      rd(a);
      chk({h, d}, {1'b1, e});
    end
  endtask
  task toggle_wait(output integer n);
    reg w;
    begin
      w = s_wave;
      n = 0;
      while (s_wave === w && n < 4000) begin
        @(negedge clock);
        n = n + 1;
      end
    end
  endtask
  // wave half periods must follow hold value times prescale
  task t_period(input [7:0] lo, input [7:0] hi, input [1:0] sh);
    integer n;
    reg w;
    begin
      @(negedge clock);
      toggle_wait(n);
      repeat (2) begin
        w = s_wave;
        toggle_wait(n);
        chk(n[8:0], {1'b0, w ? hi : lo} << sh);
      end
    end
  endtask
  task wreq(input sel);
    integer n;
    begin
      n = 0;
      while ((sel ? l_req : s_req) !== 1'b1 && n < 400) begin
        @(negedge clock);
        n = n + 1;
      end
      chk({8'h00, sel ? l_req : s_req}, 9'h001);
      @(negedge clock);
    end
  endtask
  task t_reset;
    begin
      rdc(8'h00, 8'h00);
      rdc(8'h03, 8'h00);
      rd(8'h10);
      chk({h, d}, 9'h000);
      @(posedge clock);
      bank_pointer <= 8'h00;
      rd(8'h00);
      chk({h, d}, 9'h000);
      @(posedge clock);
      bank_pointer <= 8'h0D;
    end
  endtask
  task t_regs;
    begin
      for (i = 4; i < 8; i = i + 1) begin
        wr(i[7:0], 8'hA0 + i[7:0]);
        rdc(i[7:0], 8'hA0 + i[7:0]);
      end
      wr(8'h0B, 8'h5A);
      rdc(8'h0B, 8'h00);
      wr(8'h04, 8'h05);
      wr(8'h05, 8'h07);
    end
  endtask
  task t_prescale;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'h00, {3'b100, i[1:0], 3'b000});
        t_period(8'h05, 8'h07, i[1:0]);
        wr(8'h00, 8'h00);
      end
    end
  endtask
  task t_single;
    begin
      wr(8'h00, 8'hC2);
      wreq(1'b0);
      rdc(8'h00, 8'h62);
      wr(8'h00, 8'h42);
      rdc(8'h00, 8'h62);
      wr(8'h00, 8'h62);
      rdc(8'h00, 8'h42);
    end
  endtask
  task t_ping;
    begin
      wr(8'h00, 8'h20);
      wr(8'h02, 8'h20);
      wr(8'h06, 8'h10);
      wr(8'h07, 8'h00);
      wr(8'h01, 8'h07);
      wr(8'h02, 8'h42);
      wr(8'h00, 8'hC2);
      repeat (3) @(negedge clock);
      chk({8'h00, s_wave}, 9'h001);
      repeat (3) begin
        wreq(1'b0);
        chk({8'h00, l_wave}, 9'h001);
        wreq(1'b1);
        chk({8'h00, s_wave}, 9'h001);
      end
      wr(8'h01, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h00);
    end
  endtask
  task t_demod;
    begin
      wr(8'h06, 8'hFF);
      wr(8'h07, 8'hFF);
      wr(8'h01, 8'h50);
      wr(8'h02, 8'h80);
      wr(8'h00, 8'h84);
      p_run <= 1'b1;
      repeat (300) @(posedge clock);
      wreq(1'b0);
      rd(8'h0B);
      h2 = d;
      rd(8'h0A);
      chk({1'b0, d - h2}, 9'h00A);
      wr(8'h0B, ~h2);
      rd(8'h0B);
      chk({1'b0, d}, {1'b0, h2});
      rdc(8'h09, 8'hFF);
      // arm one capture, then a new hold must not reach the capture
      wr(8'h02, 8'hC0);
      repeat (100) @(posedge clock);
      wr(8'h07, 8'h40);
      repeat (150) @(posedge clock);
      rdc(8'h09, 8'hFF);
      p_run <= 1'b0;
    end
  endtask
  // long wrap with no input edges, then capture on short timeout
  task t_mark;
    begin
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h20);
      wr(8'h06, 8'h20);
      wr(8'h07, 8'h00);
      wr(8'h01, 8'h40);
      wr(8'h02, 8'h82);
      wreq(1'b1);
      rdc(8'h02, 8'hA2);
      wr(8'h02, 8'hE4);
      wr(8'h00, 8'h80);
      wreq(1'b1);
    end
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    t_reset;
    t_regs;
    t_prescale;
    t_single;
    t_ping;
    t_demod;
    t_mark;
    stop_test;
  end
endmodule
